// ===== verilog/serial_master_pkg.sv
package serial_master_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CONTROL = 12'h000;
  localparam logic [11:0] OFF_SEL0_EDGE = 12'h004;
  localparam logic [11:0] OFF_SEL1_EDGE = 12'h008;
  localparam logic [11:0] OFF_START = 12'h00C;
  localparam logic [11:0] OFF_IRQ_MASKED = 12'h020;
  localparam logic [11:0] OFF_IRQ_RAW = 12'h024;
  localparam logic [11:0] OFF_IRQ_CLEAR = 12'h028;
  localparam logic [11:0] OFF_IRQ_EN_SET = 12'h02C;
  localparam logic [11:0] OFF_IRQ_EN_CLR = 12'h030;
  localparam logic [11:0] OFF_TX_ADDR = 12'h040;
  localparam logic [11:0] OFF_TX_DATA = 12'h050;
  localparam logic [11:0] OFF_RX_DATA = 12'h060;
  localparam logic [11:0] OFF_RX_QUEUE = 12'h070;
  localparam logic [11:0] OFF_QUEUE_STAT = 12'h074;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTL_TX_EN = 0;
  localparam int unsigned CTL_RX_EN = 1;
  localparam int unsigned CTL_SEL0_LVL = 2;
  localparam int unsigned CTL_SEL1_LVL = 3;
  localparam int unsigned CTL_SEL0_WE = 4;
  localparam int unsigned CTL_SEL1_WE = 5;
  localparam int unsigned CTL_AW_LSB = 8;
  localparam int unsigned CTL_AW_WE = 13;
  localparam int unsigned CTL_DW_LSB = 16;
  localparam int unsigned CTL_DW_WE = 21;
  localparam int unsigned CTL_RW_LSB = 24;
  localparam int unsigned CTL_RW_WE = 29;
  localparam int unsigned WIDTH_BITS = 5;
  localparam int unsigned EDGE_LAUNCH = 0;
  localparam int unsigned EDGE_SAMPLE = 1;

  // ----------------------------------------------------------------
  // values after reset and sizes
  // ----------------------------------------------------------------
  localparam logic [1:0] EDGE_RST = 2'h1;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [4:0] WIDTH_RST = 5'h00;
  localparam int unsigned RXQ_DEPTH = 16;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_SHIFT = 2'b11,
    ST_DONE = 2'b10
  } xfer_state_t;

  // encoded as {receive enable, transmit enable}
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_TX = 2'b01,
    MODE_CONC = 2'b10,
    MODE_RX = 2'b11
  } mode_t;

endpackage : serial_master_pkg

// ===== verilog/level_sync.sv
module level_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // asynchronous levels in, filtered levels out
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] lvl
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change is taken only once the second and third stages agree
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lvl <= '0;
    end else begin
      lvl <= (s2_r & s3_r) | (lvl & (s2_r ^ s3_r));
    end
  end

endmodule : level_sync

// ===== verilog/fifo_buffer.sv
module fifo_buffer #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic doPush;
  logic doPop;

  assign inReady = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem[rdPtr_r];
  assign doPush = inValid & inReady;
  assign doPop = outValid & outReady;

  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (doPush) begin
        wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + AW'(1);
      end
      if (doPop) begin
        rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + AW'(1);
      end
      count_r <= count_r + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end

endmodule : fifo_buffer

// ===== verilog/three_wire_serial_master.sv
// What this block does
// [RULE1] default launch of outgoing bits is on the falling serial clock edge
// [RULE2] default sampling of incoming bits is on the rising serial clock edge
// [RULE3] each select has own launch and sample edge bits; active select applies
// [RULE4] width fields hold 0 to 31, meaning one bit more than the value
// [RULE5] transmit mode sends address then data, captures nothing
// [RULE6] receive mode sends address, no data, then captures receive bits
// [RULE7] concurrent mode has no address; shifts both ways for address width
// [RULE8] shifting follows the serial core clock; registers follow the bus clock
// [RULE9] one completion interrupt, bit 0 of the masked status register
// [RULE10] registers clear on reset; both edge registers reset to one
// [RULE11] select level changes only when its write enable is set in that write
// [RULE12] each width field changes only when its own enable is set
// [RULE13] select lines follow written level bits; software owns polarity
// [RULE14] software checks no interrupt is pending before setup writes
// [RULE15] after reset software sets selects inactive, then edge selection
// [RULE16] software sets select, mode, widths, words, enable, then start
// [RULE17] software clears the interrupt and checks masked status reads zero
// [RULE18] in a burst select stays asserted; software restarts each transfer
// [RULE19] software ends by writing select inactive and clearing mode fields
// [RULE20] after reset software drives both selects to inactive levels
// [RULE21] transmit words are left-aligned and sent from bit 31 down
// [RULE22] start zeroes the receive register; received bits fill right-aligned
// [RULE23] start reads one while busy and clears itself at completion
// [RULE24] masked status reads zero unless enabled; raw status ignores enable
// [RULE25] control layout: enables, levels, level write enables, width bytes
// [RULE26] start, clear and completion cross safely into the serial sequencing
module three_wire_serial_master
  import serial_master_pkg::*;
#(
  parameter int unsigned QUEUE_DEPTH = RXQ_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // apb register port
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // serial link
  input wire logic serialCoreClock,
  input wire logic serialInLine,
  output logic serialOutLine,
  output logic selectLineZero,
  output logic selectLineOne,
  // completion interrupt
  output logic irqLine
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic txEn_r;
  logic rxEn_r;
  logic activeSel_r;
  logic [4:0] addrW_r;
  logic [4:0] dataW_r;
  logic [4:0] rxW_r;
  logic [1:0] edge0_r;
  logic [1:0] edge1_r;
  logic startBit_r;
  logic rawFlag_r;
  logic irqEn_r;
  logic [31:0] txAddr_r;
  logic [31:0] txData_r;
  logic [31:0] rxShift_r;
  xfer_state_t state_r;
  logic phase_r;
  logic [5:0] left_r;
  logic [31:0] shift_r;
  logic slotRx_r;
  logic slotDone_r;
  logic sclkPrev_r;
  logic [6:0] launchCnt_r;
  logic [6:0] expTotal_r;

  // ----------------------------------------------------------------
  // link inputs
  // ----------------------------------------------------------------
  logic [1:0] syncLvl;
  logic riseEdge;
  logic fallEdge;
  logic sdIn;

  level_sync #(.WIDTH(2)) uSync ( // [RULE26]
    .clk_sys(clk_sys),
    .reset(reset),
    .din({serialCoreClock, serialInLine}),
    .lvl(syncLvl)
  );

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sclkPrev_r <= 1'b0;
    end else begin
      sclkPrev_r <= syncLvl[1];
    end
  end

  // serial core clock edges pace all shifting
  assign riseEdge = syncLvl[1] & ~sclkPrev_r; // [RULE8]
  assign fallEdge = ~syncLvl[1] & sclkPrev_r; // [RULE8]
  assign sdIn = syncLvl[0];

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setupPh;
  logic wrEn;
  logic ctlWr;
  logic startWr;
  logic startSetWr;
  logic abortWr;
  logic irqClrWr;
  logic mapped;
  logic [31:0] rdVal;
  logic qInReady;
  logic qOutValid;
  logic qPop;
  logic [31:0] qData;

  assign setupPh = PSEL & ~PENABLE;
  assign wrEn = PSEL & PENABLE & PREADY & PWRITE;
  assign ctlWr = wrEn && (PADDR == OFF_CONTROL);
  assign startWr = wrEn && (PADDR == OFF_START);
  assign startSetWr = startWr & PWDATA[0];
  assign abortWr = startWr & ~PWDATA[0];
  assign irqClrWr = wrEn && (PADDR == OFF_IRQ_CLEAR) && PWDATA[0];
  assign qPop = setupPh & ~PWRITE & (PADDR == OFF_RX_QUEUE) & qOutValid;

  always_comb begin
    rdVal = 32'h0000_0000;
    mapped = 1'b1;
    case (PADDR)
      OFF_CONTROL: rdVal = {3'h0, rxW_r, 3'h0, dataW_r, 3'h0, addrW_r, 4'h0,
                            selectLineOne, selectLineZero, rxEn_r, txEn_r};
      OFF_SEL0_EDGE: rdVal = {30'h0, edge0_r};
      OFF_SEL1_EDGE: rdVal = {30'h0, edge1_r};
      OFF_START: rdVal = {31'h0, startBit_r}; // [RULE23]
      OFF_IRQ_MASKED: rdVal = {31'h0, rawFlag_r & irqEn_r}; // [RULE24] [RULE9]
      OFF_IRQ_RAW: rdVal = {31'h0, rawFlag_r}; // [RULE24]
      OFF_IRQ_CLEAR: rdVal = 32'h0000_0000;
      OFF_IRQ_EN_SET: rdVal = {31'h0, irqEn_r};
      OFF_IRQ_EN_CLR: rdVal = 32'h0000_0000;
      OFF_TX_ADDR: rdVal = txAddr_r;
      OFF_TX_DATA: rdVal = txData_r;
      OFF_RX_DATA: rdVal = rxShift_r;
      OFF_RX_QUEUE: rdVal = qOutValid ? qData : 32'h0000_0000;
      OFF_QUEUE_STAT: rdVal = {31'h0, qOutValid};
      default: mapped = 1'b0;
    endcase
  end

  // registered answer: ready comes in the first access cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      PREADY <= 1'b0;
      PRDATA <= WORD_RST;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= setupPh;
      PSLVERR <= setupPh & ~mapped;
      if (setupPh) begin
        PRDATA <= PWRITE ? WORD_RST : rdVal;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin // [RULE10]
      txEn_r <= 1'b0;
      rxEn_r <= 1'b0;
      selectLineZero <= 1'b0;
      selectLineOne <= 1'b0;
      activeSel_r <= 1'b0;
      addrW_r <= WIDTH_RST;
      dataW_r <= WIDTH_RST;
      rxW_r <= WIDTH_RST;
    end else if (ctlWr) begin // [RULE25]
      txEn_r <= PWDATA[CTL_TX_EN];
      rxEn_r <= PWDATA[CTL_RX_EN];
      if (PWDATA[CTL_SEL0_WE]) begin
        selectLineZero <= PWDATA[CTL_SEL0_LVL]; // [RULE11] [RULE13] [RULE18]
      end
      if (PWDATA[CTL_SEL1_WE]) begin
        selectLineOne <= PWDATA[CTL_SEL1_LVL]; // [RULE11] [RULE13]
      end
      // the select written alone picks whose edge settings apply
      if (PWDATA[CTL_SEL0_WE] ^ PWDATA[CTL_SEL1_WE]) begin
        activeSel_r <= PWDATA[CTL_SEL1_WE]; // [RULE3]
      end
      if (PWDATA[CTL_AW_WE]) begin
        addrW_r <= PWDATA[CTL_AW_LSB +: WIDTH_BITS]; // [RULE12]
      end
      if (PWDATA[CTL_DW_WE]) begin
        dataW_r <= PWDATA[CTL_DW_LSB +: WIDTH_BITS]; // [RULE12]
      end
      if (PWDATA[CTL_RW_WE]) begin
        rxW_r <= PWDATA[CTL_RW_LSB +: WIDTH_BITS]; // [RULE12]
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      edge0_r <= EDGE_RST; // [RULE1] [RULE2] [RULE10]
      edge1_r <= EDGE_RST; // [RULE1] [RULE2] [RULE10]
      txAddr_r <= WORD_RST;
      txData_r <= WORD_RST;
      irqEn_r <= 1'b0;
    end else if (wrEn) begin
      if (PADDR == OFF_SEL0_EDGE) begin
        edge0_r <= PWDATA[1:0];
      end
      if (PADDR == OFF_SEL1_EDGE) begin
        edge1_r <= PWDATA[1:0];
      end
      if (PADDR == OFF_TX_ADDR) begin
        txAddr_r <= PWDATA;
      end
      if (PADDR == OFF_TX_DATA) begin
        txData_r <= PWDATA;
      end
      if ((PADDR == OFF_IRQ_EN_SET) && PWDATA[0]) begin
        irqEn_r <= 1'b1;
      end else if ((PADDR == OFF_IRQ_EN_CLR) && PWDATA[0]) begin
        irqEn_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  mode_t mode;
  logic [1:0] edgeCfg;
  logic launchEdge;
  logic sampleEdge;
  logic goFire;
  logic doneEvt;
  logic capture;
  logic [5:0] addrLen;
  logic [5:0] payLen;

  assign mode = mode_t'({rxEn_r, txEn_r});
  assign edgeCfg = activeSel_r ? edge1_r : edge0_r;
  assign launchEdge = edgeCfg[EDGE_LAUNCH] ? fallEdge : riseEdge; // [RULE3]
  assign sampleEdge = edgeCfg[EDGE_SAMPLE] ? fallEdge : riseEdge; // [RULE3]
  assign addrLen = {1'b0, addrW_r} + 6'd1; // [RULE4]
  assign payLen = (mode == MODE_RX) ? {1'b0, rxW_r} + 6'd1 : {1'b0, dataW_r} + 6'd1; // [RULE4]
  // a pending interrupt or a missing mode leaves start set and idle
  assign goFire = (state_r == ST_IDLE) & startBit_r & ~rawFlag_r & (mode != MODE_OFF)
                  & qInReady;
  assign doneEvt = (state_r == ST_DONE);
  assign capture = sampleEdge & slotRx_r & ~slotDone_r;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
      phase_r <= 1'b0;
      left_r <= 6'd0;
      shift_r <= WORD_RST;
      slotRx_r <= 1'b0;
      slotDone_r <= 1'b0;
      serialOutLine <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (goFire) begin
            state_r <= ST_LEAD;
            phase_r <= (mode == MODE_CONC); // [RULE7]
            left_r <= addrLen;
            shift_r <= (mode == MODE_CONC) ? txData_r : txAddr_r; // [RULE7]
          end
        end
        ST_LEAD, ST_SHIFT: begin
          if (abortWr) begin
            state_r <= ST_IDLE;
            serialOutLine <= 1'b0;
            slotRx_r <= 1'b0;
          end else if (launchEdge && (left_r != 6'd0)) begin
            // receive slots of receive mode drive nothing useful
            serialOutLine <= (phase_r && (mode == MODE_RX)) ? 1'b0 : shift_r[31]; // [RULE6] [RULE21] [RULE1]
            slotRx_r <= phase_r && (mode != MODE_TX); // [RULE5]
            slotDone_r <= 1'b0;
            state_r <= ST_SHIFT;
            if (!phase_r && (left_r == 6'd1)) begin
              phase_r <= 1'b1;
              left_r <= payLen; // [RULE5] [RULE6]
              shift_r <= txData_r;
            end else begin
              left_r <= left_r - 6'd1;
              shift_r <= {shift_r[30:0], 1'b0}; // [RULE21]
            end
          end else if (launchEdge) begin
            state_r <= ST_DONE;
            serialOutLine <= 1'b0;
            slotRx_r <= 1'b0;
          end else if (capture) begin
            slotDone_r <= 1'b1;
          end
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // capture runs before any launch in the same edge, so equal edges still work
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rxShift_r <= WORD_RST;
    end else if (startSetWr) begin
      rxShift_r <= WORD_RST; // [RULE22]
    end else if (capture) begin
      rxShift_r <= {rxShift_r[30:0], sdIn}; // [RULE2] [RULE22]
    end
  end

  // ----------------------------------------------------------------
  // start, completion and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      startBit_r <= 1'b0;
      rawFlag_r <= 1'b0;
      irqLine <= 1'b0;
    end else begin
      if (startWr) begin
        startBit_r <= PWDATA[0];
      end else if (doneEvt) begin
        startBit_r <= 1'b0; // [RULE23]
      end
      if (doneEvt) begin
        rawFlag_r <= 1'b1; // [RULE9]
      end else if (irqClrWr) begin
        rawFlag_r <= 1'b0;
      end
      irqLine <= rawFlag_r & irqEn_r; // [RULE9] [RULE24]
    end
  end

  // finished receive words queue up; a full queue holds off the next start
  fifo_buffer #(.WIDTH(32), .DEPTH(QUEUE_DEPTH)) uQueue (
    .clk_sys(clk_sys),
    .reset(reset),
    .inValid(doneEvt && (mode != MODE_TX)),
    .inReady(qInReady),
    .inData(rxShift_r),
    .outValid(qOutValid),
    .outReady(qPop),
    .outData(qData)
  );

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      launchCnt_r <= 7'd0;
      expTotal_r <= 7'd0;
    end else if (goFire) begin
      launchCnt_r <= 7'd0;
      expTotal_r <= (mode == MODE_CONC) ? {1'b0, addrLen} : {1'b0, addrLen} + {1'b0, payLen};
    end else if ((state_r != ST_IDLE) && launchEdge && (left_r != 6'd0)) begin
      launchCnt_r <= launchCnt_r + 7'd1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  launch_edge_a: assert property ( // [RULE1] [RULE3]
    $changed(serialOutLine) |-> $past(launchEdge) || $past(abortWr))
    else $error("serial out moved off a launch edge");
  sample_edge_a: assert property ( // [RULE2] [RULE22]
    $changed(rxShift_r) |-> $past(sampleEdge) || $past(startSetWr))
    else $error("receive word moved off a sample edge");
  rx_clear_a: assert property ( // [RULE22]
    startSetWr |=> rxShift_r == 32'h0000_0000)
    else $error("start did not zero receive word");
  width_total_a: assert property ( // [RULE4]
    state_r == ST_DONE |-> launchCnt_r == expTotal_r)
    else $error("bit count differs from widths");
  tx_quiet_a: assert property ( // [RULE5]
    (state_r != ST_IDLE) && (mode == MODE_TX) && !startSetWr |=> $stable(rxShift_r))
    else $error("transmit mode captured data");
  rx_no_data_a: assert property ( // [RULE6]
    slotRx_r && (mode == MODE_RX) |-> !serialOutLine)
    else $error("receive slot drove data");
  conc_no_addr_a: assert property ( // [RULE7]
    goFire && (mode == MODE_CONC) |=> phase_r && (left_r == $past(addrLen)))
    else $error("concurrent mode started an address phase");
  done_flags_a: assert property ( // [RULE23] [RULE9]
    (state_r == ST_DONE) && !startWr |=> !startBit_r && rawFlag_r)
    else $error("completion did not clear start and set flag");
  set_wins_a: assert property ( // [RULE9]
    doneEvt && irqClrWr |=> rawFlag_r)
    else $error("clear beat a completion");
  irq_gate_a: assert property ( // [RULE24]
    !irqEn_r [*2] |-> !irqLine)
    else $error("interrupt shown while disabled");
  sel_keep_a: assert property ( // [RULE11]
    ctlWr && !PWDATA[CTL_SEL0_WE] |=> $stable(selectLineZero))
    else $error("select zero changed without enable");
  sel_level_a: assert property ( // [RULE13]
    ctlWr && PWDATA[CTL_SEL1_WE] |=> selectLineOne == $past(PWDATA[CTL_SEL1_LVL]))
    else $error("select one not at written level");
  width_keep_a: assert property ( // [RULE12]
    ctlWr && !PWDATA[CTL_AW_WE] |=> $stable(addrW_r))
    else $error("address width changed without enable");

  tx_done_c: cover property (doneEvt && (mode == MODE_TX));
  rx_done_c: cover property (doneEvt && (mode == MODE_RX));
  conc_done_c: cover property (doneEvt && (mode == MODE_CONC));
  abort_c: cover property ((state_r == ST_SHIFT) && abortWr);

endmodule : three_wire_serial_master

// ===== dv/serial_slave_model.sv
module serial_slave_model (
  // link
  output logic serialCoreClock,
  input wire logic serialOutLine,
  output logic serialInLine,
  // scenario control
  input wire logic arm,
  input wire logic [5:0] skipN,
  input wire logic [5:0] capN,
  input wire logic [31:0] respWord,
  input wire logic [1:0] edges,
  output logic [31:0] gotWord
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] sr;
  int fallCnt;
  int riseCnt;
  initial begin
    serialCoreClock = 1'b0;
    serialInLine = 1'b0;
    gotWord = '0;
    sr = '0;
    fallCnt = 99;
    riseCnt = 99;
  end
  always #80 serialCoreClock = ~serialCoreClock;
  always @(posedge arm) begin
    fallCnt = 0;
    riseCnt = 0;
    sr = respWord;
    gotWord = '0;
  end
  // reply launched opposite the master's sample edge, captured opposite its launch edge;
  // outside the reply the line toggles so stale bits never match
  always @(serialCoreClock) begin
    if (serialCoreClock === edges[1]) begin
      fallCnt++;
      if (fallCnt > skipN && fallCnt <= skipN + 32) begin
        serialInLine <= sr[31];
        sr <= sr << 1;
      end else begin
        serialInLine <= ~serialInLine;
      end
    end
    if (serialCoreClock === edges[0]) begin
      riseCnt++;
      if (riseCnt <= capN) begin
        gotWord <= {gotWord[30:0], serialOutLine};
      end
    end
  end
endmodule : serial_slave_model

// ===== dv/three_wire_serial_master_bench.sv
module three_wire_serial_master_bench;
  import serial_master_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, arm = 1'b0;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0, respWord = '0, PRDATA, gotWord, q;
  logic [5:0] skipN = '0, capN = '0;
  logic [1:0] edges = 2'h1;
  logic PREADY, PSLVERR, serialCoreClock, serialInLine, serialOutLine;
  logic selectLineZero, selectLineOne, irqLine, err;
  int error_cnt = 0;
  int num_checks = 0;
  always #2 clk_sys = ~clk_sys;
  three_wire_serial_master #(.QUEUE_DEPTH(16)) DUT (.clk_sys(clk_sys), .reset(reset),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .serialCoreClock(serialCoreClock),
    .serialInLine(serialInLine), .serialOutLine(serialOutLine),
    .selectLineZero(selectLineZero), .selectLineOne(selectLineOne), .irqLine(irqLine));
  serial_slave_model slave (.serialCoreClock(serialCoreClock), .serialOutLine(serialOutLine),
    .serialInLine(serialInLine), .arm(arm), .skipN(skipN), .capN(capN),
    .respWord(respWord), .edges(edges), .gotWord(gotWord));
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    PSEL = 1'b1;
    PENABLE = 1'b0;
    PWRITE = wr;
    PADDR = a;
    PWDATA = d;
    @(negedge clk_sys);
    PENABLE = 1'b1;
    for (int n = 0; n < 8 && PREADY !== 1'b1; n++) @(negedge clk_sys);
    q = PRDATA;
    err = PSLVERR;
    @(negedge clk_sys);
    PSEL = 1'b0;
    PENABLE = 1'b0;
  endtask : apb
  // start is lined up just after a link rising edge so the slave counts slots from arm
  task automatic xfer(input logic [31:0] ctl, a, d, r, input logic [5:0] sk, cp);
    apb(1'b0, OFF_IRQ_RAW, '0);
    chk(q, 32'h0000_0000);
    apb(1'b1, OFF_CONTROL, ctl);
    apb(1'b1, OFF_TX_ADDR, a);
    apb(1'b1, OFF_TX_DATA, d);
    respWord = r;
    skipN = sk;
    capN = cp;
    @(posedge serialCoreClock);
    apb(1'b1, OFF_START, 32'h0000_0001);
    arm = 1'b1;
    apb(1'b0, OFF_START, '0);
    chk(q, 32'h0000_0001);
    arm = 1'b0;
    for (int n = 0; n < 400; n++) begin
      apb(1'b0, OFF_IRQ_RAW, '0);
      if (q[0] === 1'b1) break;
    end
    chk(q, 32'h0000_0001);
    apb(1'b0, OFF_START, '0);
    chk(q, 32'h0000_0000);
  endtask : xfer
  task automatic t_reset;
    logic [11:0] offs [7];
    offs = '{OFF_CONTROL, OFF_SEL0_EDGE, OFF_SEL1_EDGE, OFF_START, OFF_IRQ_EN_SET,
      OFF_TX_ADDR, OFF_TX_DATA};
    chk(32'({selectLineZero, selectLineOne, serialOutLine, irqLine}), '0);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, offs[i], '0);
      chk(q, (i == 1 || i == 2) ? 32'h0000_0001 : 32'h0000_0000);
    end
    apb(1'b0, 12'h0FC, '0);
    chk({q[31:1], err}, 32'h0000_0001);
  endtask : t_reset
  task automatic t_select;
    apb(1'b1, OFF_CONTROL, 32'h0000_0030);
    chk(32'({selectLineZero, selectLineOne}), 32'h0);
    apb(1'b1, OFF_CONTROL, 32'h0000_0014);
    chk(32'({selectLineZero, selectLineOne}), 32'h2);
    apb(1'b1, OFF_CONTROL, 32'h0000_0708);
    chk(32'({selectLineZero, selectLineOne}), 32'h2);
    apb(1'b0, OFF_CONTROL, '0);
    chk(q, 32'h0000_0004);
  endtask : t_select
  task automatic t_receive;
    xfer(32'h2700_2303, 32'hA000_0000, '0, 32'hC300_0000, 6'd4, 6'd12);
    chk(gotWord, 32'h0000_0A00);
    apb(1'b0, OFF_RX_DATA, '0);
    chk(q, 32'h0000_00C3);
    apb(1'b0, OFF_IRQ_MASKED, '0);
    chk({q[31:1], irqLine}, 32'h0);
    apb(1'b1, OFF_IRQ_CLEAR, 32'h0000_0001);
    apb(1'b0, OFF_IRQ_RAW, '0);
    chk(q, 32'h0);
  endtask : t_receive
  task automatic t_transmit;
    apb(1'b1, OFF_IRQ_EN_SET, 32'h0000_0001);
    xfer(32'h0027_2715, 32'hA500_0000, 32'h3C00_0000, '0, 6'd0, 6'd16);
    chk(gotWord, 32'h0000_A53C);
    apb(1'b0, OFF_IRQ_MASKED, '0);
    chk({q[31:1], irqLine}, 32'h1);
    apb(1'b0, OFF_RX_DATA, '0);
    chk(q, 32'h0);
    apb(1'b1, OFF_IRQ_CLEAR, 32'h0000_0001);
    apb(1'b0, OFF_IRQ_MASKED, '0);
    chk(q, 32'h0);
  endtask : t_transmit
  task automatic t_concurrent;
    xfer(32'h0000_2702, '0, 32'h9600_0000, 32'h5A00_0000, 6'd0, 6'd8);
    chk(gotWord, 32'h0000_0096);
    apb(1'b0, OFF_RX_DATA, '0);
    chk(q, 32'h0000_005A);
    apb(1'b0, OFF_RX_QUEUE, '0);
    chk(q, 32'h0000_00C3);
    chk(32'(selectLineZero), 32'h1);
    apb(1'b1, OFF_IRQ_CLEAR, 32'h0000_0001);
    apb(1'b1, OFF_CONTROL, 32'h0000_0010);
    chk(32'(selectLineZero), 32'h0);
  endtask : t_concurrent
  // select one with launch and sample both on falling edges
  task automatic t_edges;
    apb(1'b1, OFF_SEL1_EDGE, 32'h0000_0003);
    apb(1'b0, OFF_SEL1_EDGE, '0);
    chk(q, 32'h0000_0003);
    edges = 2'h3;
    xfer(32'h2700_272B, 32'h5C00_0000, '0, 32'hE100_0000, 6'd8, 6'd16);
    chk(gotWord, 32'h0000_5C00);
    apb(1'b0, OFF_RX_DATA, '0);
    chk(q, 32'h0000_00E1);
    chk(32'(selectLineOne), 32'h1);
    apb(1'b1, OFF_IRQ_CLEAR, 32'h0000_0001);
    apb(1'b1, OFF_CONTROL, 32'h0000_0020);
    chk(32'(selectLineOne), 32'h0);
  endtask : t_edges
  initial begin
    repeat (12) @(negedge clk_sys);
    reset = 1'b0;
    t_reset();
    t_select();
    t_receive();
    t_transmit();
    t_concurrent();
    t_edges();
    give_verdict();
  end
  // four transfers of up to 16 slots take well under this span
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
endmodule : three_wire_serial_master_bench
